// file: hdl/irq_pkg.sv
package irq_pkg;
  localparam logic [7:0] MASK_ADDR = 8'hDD;
  localparam logic [7:0] PEND_ADDR = 8'hF4;
  // Mask powers up undefined on silicon; a defined all-masked value is used here
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [5:0] PEND_RESET = 6'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  localparam logic [1:0] PEND_UNUSED_BITS = 2'h0;
  localparam int PEND_WIDTH = 6;
  // Pending bit positions
  localparam int PND_TA_OVF = 0;
  localparam int PND_TA_MATCH = 1;
  localparam int PND_D0_OVF = 2;
  localparam int PND_D0_MATCH = 3;
  localparam int PND_D1_OVF = 4;
  localparam int PND_D1_MATCH = 5;
  // Interrupt level positions
  localparam int LVL_TIMER_A = 0;
  localparam int LVL_TIMER_B = 1;
  localparam int LVL_TIMER_C = 2;
  localparam int LVL_TIMER_D = 3;
  localparam int LVL_WATCH_SIO = 4;
  localparam int LVL_UART = 5;
  localparam int LVL_EXT_P2 = 6;
  localparam int LVL_EXT_P4 = 7;
endpackage

// file: hdl/pending_flag.sv
`timescale 1ns/100ps
module pending_flag
  import irq_pkg::*;
#(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic set_evt,
  input wire logic clear_req,
  output logic flag
);
  logic flag_reg;
  logic flag_next;

  // Set beats clear so an event landing in the clear cycle is kept
  always_comb begin
    flag_next = flag_reg;
    if (set_evt) begin
      flag_next = 1'b1;
    end else if (clear_req) begin
      flag_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_reg <= RESET_VALUE;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;
endmodule // pending_flag

// file: hdl/irq_mask_and_timer_pending.sv
// Summary of operation
// R1: Mask bit n enables level n; zero blocks that level's requests.
// R2: Level 5 enable gates both UART channels' transmit and receive requests.
// R3: Level 4 enable gates watch timer and sync serial port requests.
// R4: Level 3 enable gates both dual timer channels' match/capture and overflow.
// R5: Level 2 enable gates match and overflow of the second timer pair.
// R6: Level 1 enable gates the timer B match request.
// R7: Level 0 enable gates timer A match/capture and overflow requests.
// R8: Each pending bit reads one while pending, zero otherwise.
// R9: Writing zero to a pending bit clears that flag.
// R10: Pending bit 1 flags timer A match or capture.
// R11: Pending bit 2 flags dual timer channel zero overflow.
// R12: Pending bit 0 flags timer A overflow; zero write clears it.
// R13: Bits 5,4,3 flag channel one match, channel one overflow, channel zero match.
// R14: Events set pending flags; writing one leaves a flag unchanged.
`timescale 1ns/100ps
module irq_mask_and_timer_pending
  import irq_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic TIMER_A_OVF_EVT,
  input wire logic TIMER_A_MATCH_EVT,
  input wire logic DUAL_TIMER_CHANNEL_ZERO_OVF_EVT,
  input wire logic DUAL_TIMER_CHANNEL_ZERO_MATCH_EVT,
  input wire logic DUAL_TIMER_CHANNEL_ONE_OVF_EVT,
  input wire logic DUAL_TIMER_CHANNEL_ONE_MATCH_EVT,
  input wire logic SECOND_DUAL_TIMER_PAIR_MATCH_REQ,
  input wire logic SECOND_DUAL_TIMER_PAIR_OVF_REQ,
  input wire logic TIMER_B_MATCH_REQ,
  input wire logic WATCH_TIMER_REQ,
  input wire logic SYNC_SERIAL_PORT_REQ,
  input wire logic UART0_TX_REQ,
  input wire logic UART0_RX_REQ,
  input wire logic UART1_TX_REQ,
  input wire logic UART1_RX_REQ,
  input wire logic EXT_P2_REQ,
  input wire logic EXT_P4_REQ,
  output logic [7:0] IRQ_LEVEL
);
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] irq_reg;
  logic [7:0] irq_next;
  logic [7:0] lvl_req;
  logic [PEND_WIDTH-1:0] pend;
  logic [PEND_WIDTH-1:0] pend_set;
  logic [PEND_WIDTH-1:0] pend_clr;
  logic mask_wr;
  logic pend_wr;

  assign mask_wr = REG_WR && (REG_ADDR == MASK_ADDR);
  assign pend_wr = REG_WR && (REG_ADDR == PEND_ADDR);

  // Event to pending bit map
  always_comb begin
    pend_set = '0;
    pend_set[PND_TA_OVF] = TIMER_A_OVF_EVT; // [R12]
    pend_set[PND_TA_MATCH] = TIMER_A_MATCH_EVT; // [R10]
    pend_set[PND_D0_OVF] = DUAL_TIMER_CHANNEL_ZERO_OVF_EVT; // [R11]
    pend_set[PND_D0_MATCH] = DUAL_TIMER_CHANNEL_ZERO_MATCH_EVT; // [R13]
    pend_set[PND_D1_OVF] = DUAL_TIMER_CHANNEL_ONE_OVF_EVT; // [R13]
    pend_set[PND_D1_MATCH] = DUAL_TIMER_CHANNEL_ONE_MATCH_EVT; // [R13]
  end

  // Only zeros clear; ones leave the flag alone
  assign pend_clr = pend_wr ? ~REG_WDATA[PEND_WIDTH-1:0] : '0; // [R9] [R14]

  genvar gi;
  generate
    for (gi = 0; gi < PEND_WIDTH; gi++) begin : g_pend
      pending_flag #(
        .RESET_VALUE(PEND_RESET[gi])
      ) u_flag (
        .clk(MCLK),
        .reset_n(RESETN),
        .set_evt(pend_set[gi]), // [R14]
        .clear_req(pend_clr[gi]), // [R9]
        .flag(pend[gi])
      );
    end
  endgenerate

  // Per-level request before masking
  always_comb begin
    lvl_req = '0;
    lvl_req[LVL_TIMER_A] = pend[PND_TA_OVF] | pend[PND_TA_MATCH]; // [R7]
    lvl_req[LVL_TIMER_B] = TIMER_B_MATCH_REQ; // [R6]
    lvl_req[LVL_TIMER_C] = SECOND_DUAL_TIMER_PAIR_MATCH_REQ
                         | SECOND_DUAL_TIMER_PAIR_OVF_REQ; // [R5]
    lvl_req[LVL_TIMER_D] = |pend[PND_D1_MATCH:PND_D0_OVF]; // [R4]
    lvl_req[LVL_WATCH_SIO] = WATCH_TIMER_REQ | SYNC_SERIAL_PORT_REQ; // [R3]
    lvl_req[LVL_UART] = UART0_TX_REQ | UART0_RX_REQ
                      | UART1_TX_REQ | UART1_RX_REQ; // [R2]
    lvl_req[LVL_EXT_P2] = EXT_P2_REQ;
    lvl_req[LVL_EXT_P4] = EXT_P4_REQ;
  end

  always_comb begin
    mask_next = mask_reg;
    if (mask_wr) begin
      mask_next = REG_WDATA; // [R1]
    end
    // Registered gate keeps the output glitch free at one cycle of latency
    irq_next = lvl_req & mask_reg; // [R1]
  end

  // Read data is held between reads
  always_comb begin
    rdata_next = rdata_reg;
    if (REG_RD) begin
      if (REG_ADDR == MASK_ADDR) begin
        rdata_next = mask_reg;
      end else if (REG_ADDR == PEND_ADDR) begin
        rdata_next = {PEND_UNUSED_BITS, pend}; // [R8] [R13]
      end else begin
        rdata_next = UNMAPPED_DATA;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      mask_reg <= MASK_RESET;
      irq_reg <= '0;
      rdata_reg <= UNMAPPED_DATA;
    end else begin
      mask_reg <= mask_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
    end
  end

  assign IRQ_LEVEL = irq_reg;
  assign REG_RDATA = rdata_reg;

  mask_write_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [R1]
    mask_wr |=> mask_reg == $past(REG_WDATA))
    else $error("mask register did not take written value");

  masked_level_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [R1]
    ##1 (IRQ_LEVEL & ~$past(mask_reg)) == 8'h00)
    else $error("masked level raised a request");

  uart_gate_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [R2]
    (mask_reg[LVL_UART] && (UART0_TX_REQ || UART0_RX_REQ || UART1_TX_REQ || UART1_RX_REQ))
    |=> IRQ_LEVEL[LVL_UART])
    else $error("uart request not passed on level 5");

  watch_sio_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [R3]
    (mask_reg[LVL_WATCH_SIO] && (WATCH_TIMER_REQ || SYNC_SERIAL_PORT_REQ))
    |=> IRQ_LEVEL[LVL_WATCH_SIO])
    else $error("watch or serial request not passed on level 4");

  timer_d_level_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [R4]
    ##1 IRQ_LEVEL[LVL_TIMER_D] == ($past(mask_reg[LVL_TIMER_D]) && |$past(pend[5:2])))
    else $error("level 3 does not follow dual timer pending flags");

  timer_c_gate_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [R5]
    (mask_reg[LVL_TIMER_C]
      && (SECOND_DUAL_TIMER_PAIR_MATCH_REQ || SECOND_DUAL_TIMER_PAIR_OVF_REQ))
    |=> IRQ_LEVEL[LVL_TIMER_C])
    else $error("second timer pair request not passed on level 2");

  timer_b_gate_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [R6]
    (mask_reg[LVL_TIMER_B] && TIMER_B_MATCH_REQ) |=> IRQ_LEVEL[LVL_TIMER_B])
    else $error("timer B request not passed on level 1");

  timer_a_event_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [R7]
    (mask_reg[LVL_TIMER_A] && !mask_wr && TIMER_A_MATCH_EVT) |=> ##1 IRQ_LEVEL[LVL_TIMER_A])
    else $error("timer A event not raised on level 0 two cycles later");

  pend_read_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [R8]
    (REG_RD && REG_ADDR == PEND_ADDR) |=> REG_RDATA == {2'h0, $past(pend)})
    else $error("pending read does not show flags");

  pend_clear_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [R9]
    (pend_wr && !REG_WDATA[PND_D0_MATCH] && !DUAL_TIMER_CHANNEL_ZERO_MATCH_EVT)
    |=> !pend[PND_D0_MATCH])
    else $error("zero write did not clear pending flag");

  match_set_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [R10]
    TIMER_A_MATCH_EVT |=> pend[PND_TA_MATCH] [*1] ##0 pend[1])
    else $error("timer A match not flagged in bit 1");

  d0_ovf_set_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [R11]
    DUAL_TIMER_CHANNEL_ZERO_OVF_EVT |=> pend[2])
    else $error("channel zero overflow not flagged in bit 2");

  ta_ovf_cycle_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [R12]
    (TIMER_A_OVF_EVT && pend_wr && !REG_WDATA[0]) |=> pend[0])
    else $error("timer A overflow lost when cleared in same cycle");

  unused_zero_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [R13]
    (REG_RD && REG_ADDR == PEND_ADDR) |=> REG_RDATA[7:6] == 2'h0)
    else $error("unused pending bits read nonzero");

  one_write_keep_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [R14]
    (pend_wr && REG_WDATA[5:0] == 6'h3F && pend_set == 6'h00) |=> pend == $past(pend))
    else $error("writing ones changed pending flags");

  event_sets_all_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [R14]
    (|pend_set) |=> (pend & $past(pend_set)) == $past(pend_set))
    else $error("timer event did not set its pending flag");

  zero_write_clears_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [R9]
    pend_wr |=> (pend & ~$past(REG_WDATA[PEND_WIDTH-1:0]) & ~$past(pend_set)) == 6'h00)
    else $error("zero write left a pending flag set");

  timer_a_level_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [R7]
    ##1 IRQ_LEVEL[LVL_TIMER_A] == ($past(mask_reg[LVL_TIMER_A]) && |$past(pend[1:0])))
    else $error("level 0 does not follow timer A pending flags");

  d1_match_set_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [R13]
    DUAL_TIMER_CHANNEL_ONE_MATCH_EVT |=> pend[PND_D1_MATCH])
    else $error("channel one match not flagged in bit 5");
endmodule // irq_mask_and_timer_pending

// file: dv/cpu_model.sv
`timescale 1ns/100ps
module cpu_model (
  input wire logic clk,
  output logic [7:0] addr,
  output logic wr,
  output logic [7:0] wdata,
  output logic rd,
  input wire logic [7:0] rdata
);
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    wdata = 8'h00;
    rd = 1'b0;
  end
  // Zero bits in a pending write clear those flags
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
    wdata = ~d;
  endtask
  // Data is registered at the read edge, so it is taken just after it
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    d = rdata;
  endtask
endmodule // cpu_model

// file: dv/irq_mask_and_timer_pending_tb.sv
`timescale 1ns/100ps
module irq_mask_and_timer_pending_tb;
  import irq_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr, wdata, rdata, irq, d, m, c;
  logic wr, rd;
  logic [10:0] req = 11'h000;
  logic [5:0] ev = 6'h00;
  logic [5:0] p;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  always #2 mclk = ~mclk;
  cpu_model cpu (.clk(mclk), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd), .rdata(rdata));
  irq_mask_and_timer_pending dut (.MCLK(mclk), .RESETN(resetn), .REG_ADDR(addr),
    .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata),
    .TIMER_A_OVF_EVT(ev[0]), .TIMER_A_MATCH_EVT(ev[1]),
    .DUAL_TIMER_CHANNEL_ZERO_OVF_EVT(ev[2]), .DUAL_TIMER_CHANNEL_ZERO_MATCH_EVT(ev[3]),
    .DUAL_TIMER_CHANNEL_ONE_OVF_EVT(ev[4]), .DUAL_TIMER_CHANNEL_ONE_MATCH_EVT(ev[5]),
    .SECOND_DUAL_TIMER_PAIR_MATCH_REQ(req[0]), .SECOND_DUAL_TIMER_PAIR_OVF_REQ(req[1]),
    .TIMER_B_MATCH_REQ(req[2]), .WATCH_TIMER_REQ(req[3]), .SYNC_SERIAL_PORT_REQ(req[4]),
    .UART0_TX_REQ(req[5]), .UART0_RX_REQ(req[6]), .UART1_TX_REQ(req[7]),
    .UART1_RX_REQ(req[8]), .EXT_P2_REQ(req[9]), .EXT_P4_REQ(req[10]), .IRQ_LEVEL(irq));
  function automatic logic [7:0] exp_lvl(input logic [7:0] mk, input logic [10:0] r,
    input logic [5:0] pd);
    return {r[10], r[9], |r[8:5], r[3] | r[4], |pd[5:2], r[0] | r[1], r[2], |pd[1:0]} & mk;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Whole run is under a thousand cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(52));
    repeat (2) @(posedge mclk);
    #1;
    resetn = 1'b1;
    cpu.rd_reg(MASK_ADDR, d);
    check(d, MASK_RESET, "mask reset");
    cpu.rd_reg(PEND_ADDR, d);
    check(d, {PEND_UNUSED_BITS, PEND_RESET}, "pending reset");
    cpu.rd_reg(8'h00, d);
    check(d, UNMAPPED_DATA, "unmapped read");
    check(irq, 8'h00, "level reset");
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      m = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      req = (i < 2) ? 11'h7FF : 11'($urandom);
      cpu.wr_reg(MASK_ADDR, m);
      @(posedge mclk);
      #1;
      check(irq, exp_lvl(m, req, 6'h00), "level gating");
      cpu.rd_reg(MASK_ADDR, d);
      check(d, m, "mask readback");
    end
    cpu.wr_reg(8'h00, ~m);
    cpu.rd_reg(MASK_ADDR, d);
    check(d, m, "unmapped write ignored");
    req = 11'h000;
    $display("test mask done");
    for (int i = 0; i < 12; i++) begin
      m = (i < 6) ? 8'hFF : 8'($urandom);
      p = (i < 6) ? (6'h01 << i) : 6'($urandom);
      c = 8'($urandom);
      cpu.wr_reg(MASK_ADDR, m);
      @(posedge mclk);
      #1;
      ev = p;
      @(posedge mclk);
      #1;
      ev = 6'h00;
      @(posedge mclk);
      #1;
      check(irq, exp_lvl(m, 11'h000, p), "pending level");
      cpu.wr_reg(PEND_ADDR, 8'hFF);
      cpu.rd_reg(PEND_ADDR, d);
      check(d, {2'b00, p}, "pending set");
      cpu.wr_reg(PEND_ADDR, c);
      cpu.rd_reg(PEND_ADDR, d);
      check(d, {2'b00, p & c[5:0]}, "pending clear");
      cpu.wr_reg(PEND_ADDR, 8'h00);
      cpu.rd_reg(PEND_ADDR, d);
      check(irq, 8'h00, "level after clear");
      check(d, 8'h00, "pending empty");
    end
    $display("test pending done");
    cpu.wr_reg(MASK_ADDR, 8'hFF);
    // Event and zero write land on the same edge; the event must survive
    fork
      cpu.wr_reg(PEND_ADDR, 8'h00);
      begin
        @(posedge mclk);
        #1;
        ev = 6'h3F;
        @(posedge mclk);
        #1;
        ev = 6'h00;
      end
    join
    cpu.rd_reg(PEND_ADDR, d);
    check(d, {PEND_UNUSED_BITS, 6'h3F}, "set beats clear");
    check(irq, exp_lvl(8'hFF, 11'h000, 6'h3F), "levels after race");
    $display("test set wins done");
    @(posedge mclk);
    #1;
    resetn = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check(irq, 8'h00, "level in reset");
    check(rdata, UNMAPPED_DATA, "read data in reset");
    resetn = 1'b1;
    cpu.rd_reg(MASK_ADDR, d);
    check(d, MASK_RESET, "mask after reset");
    cpu.rd_reg(PEND_ADDR, d);
    check(d, {PEND_UNUSED_BITS, PEND_RESET}, "pending after reset");
    $display("test reset again done");
    finish_test();
  end
endmodule // irq_mask_and_timer_pending_tb
